// >>> core/pa_prot_map.svh
// Purpose: Offsets, field positions and reset values of the amplifier protection block.
// Assumes: APB byte addressing, 32-bit data.
// Notes: Definitions only.
`ifndef PA_PROT_MAP_SVH
`define PA_PROT_MAP_SVH
`define PA_OFF_CTRL 12'h000
`define PA_OFF_STATUS 12'h004
`define PA_OFF_MASK 12'h008
`define PA_OFF_STATE 12'h00c
`define PA_CTRL_MODE_LSB 0
`define PA_CTRL_RST 2'h0
`define PA_MASK_RST 6'h00
`define PA_EV_OVERLOAD 0
`define PA_EV_UNDERVOLT 1
`define PA_EV_THERMAL 2
`define PA_EV_WARN 3
`define PA_EV_BRIDGE 4
`define PA_EV_BOOT 5
`define PA_EV_W 6
`define PA_SYNC_STAGES 2
`define PA_IN_W 13
`endif

// >>> core/pa_prot_pkg.sv
// Purpose: Types of the amplifier protection block.
// Assumes: Nothing beyond the map header.
// Notes: Half-bridge index 0..3 stands for A..D.
package pa_prot_pkg;
   typedef enum logic [1:0] {
      bridged_output_mode = 2'h0,
      parallel_bridged_mode = 2'h2,
      single_ended_mode = 2'h3
   } pa_mode_t;
   typedef enum logic [1:0] {
      PA_ST_RUN = 2'h0,
      PA_ST_RECOVER = 2'h1,
      PA_ST_LATCHED = 2'h3
   } pa_state_t;
endpackage : pa_prot_pkg

// >>> core/pa_sync_if.sv
// Purpose: Carries raw pin levels into the synchroniser and synced levels back.
// Assumes: One clock domain.
// Notes: None.
`timescale 1ns/1ps
`default_nettype none
interface pa_sync_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] sync;
   modport src (output raw, input sync);
   modport dst (input raw, output sync);
endinterface : pa_sync_if
`default_nettype wire

// >>> core/pa_sync.sv
// Purpose: Two-flop synchroniser for the asynchronous protection inputs.
// Assumes: Inputs are levels.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ps
`default_nettype none
module pa_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   pa_sync_if.dst s
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= s.raw;
         sync_q <= meta_q;
      end
   end
   assign s.sync = sync_q;
endmodule : pa_sync
`default_nettype wire

// >>> core/pa_prot.sv
// Purpose: Fault collection, half-bridge shutdown and status pins of a class-D amplifier.
// Assumes: APB register access; trip inputs are asynchronous levels.
// Notes: Open-drain pins drive low only; the pin level is resolved outside.
`timescale 1ns/1ps
`default_nettype none
`include "pa_prot_map.svh"
//
// Contract
// [RL1] Fault and warning pins: active-low open-drain.
// [RL2] Any shutting fault pulls fault pin low.
// [RL3] Warning pin low above 125 C.
// [RL4] Two pins encode normal, warning, fault, both.
// [RL5] Device reset low forces fault pin high.
// [RL6] Fault puts affected stages high-Z, fault low.
// [RL7] Undervoltage self-clears; overload, thermal stay latched.
// [RL8] Local error maps to bridges per mode.
// [RL9] Mode codes 00 bridged, 10 parallel, 11 single.
// [RL10] Bootstrap undervoltage: own bridge only, no fault.
// [RL11] Controller lowers volume on warning.
// [RL12] Controller releases reset after supplies settle.
// [RL13] Thermal latch held until device reset.
// [RL14] Global fault stops all, latches; channel fault local.
// [RL15] Trip inputs synchronised before use.
module pa_prot (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic amp_reset_n_i,
   input wire logic overload_trip_i,
   input wire logic undervoltage_trip_i,
   input wire logic thermal_shutdown_error_i,
   input wire logic over_temp_i,
   input wire logic [3:0] bridge_err_i,
   input wire logic [3:0] boot_uv_i,
   output logic fault_n_o,
   output logic fault_n_oe_o,
   output logic temp_warning_n_o,
   output logic temp_warning_n_oe_o,
   output logic [3:0] hiz_o,
   output logic irq_o
);
   pa_sync_if #(.W(`PA_IN_W)) sync_bus ();
   logic amp_rst_n_s;
   logic ovl_s;
   logic uv_s;
   logic ote_s;
   logic warn_s;
   logic [3:0] br_s;
   logic [3:0] boot_s;
   logic ovl_lat_q;
   logic ote_lat_q;
   logic [3:0] br_lat_q;
   logic [3:0] hiz_d;
   logic [3:0] hiz_q;
   logic global_off;
   logic fault_any;
   logic fault_n_oe_q;
   logic warn_oe_q;
   logic irq_q;
   pa_prot_pkg::pa_mode_t mode_q;
   pa_prot_pkg::pa_state_t state_q;
   pa_prot_pkg::pa_state_t state_d;
   logic [`PA_EV_W-1:0] mask_q;
   logic [`PA_EV_W-1:0] status_q;
   logic [`PA_EV_W-1:0] ev_set;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic acc_done;
   logic hit;
   logic [31:0] rd_word;
   logic ovl_s_q;
   logic ote_s_q;
   logic uv_s_q;
   logic warn_s_q;
   logic [3:0] br_s_q;
   logic [3:0] boot_s_q;

   // Decide which half-bridges a set of local errors switches off in a given mode.
   function automatic logic [3:0] map_off(input pa_prot_pkg::pa_mode_t m,
                                          input logic [3:0] err);
      logic [3:0] off;
      off = 4'h0;
      unique case (m)
         pa_prot_pkg::bridged_output_mode, pa_prot_pkg::single_ended_mode: begin
            if (err[0]) off = off | 4'h3; // [RL8]
            if (err[1]) off = off | 4'h9; // [RL8]
            if (err[3]) off = off | 4'hc; // [RL8]
         end
         pa_prot_pkg::parallel_bridged_mode: begin
            off = (|err) ? 4'hf : 4'h0; // [RL8]
         end
         // Reserved code 01 takes the safest answer and stops everything on any error.
         default: begin
            off = (|err) ? 4'hf : 4'h0;
         end
      endcase
      return off;
   endfunction : map_off

   // Every trip input and the device reset pin pass two flops before use.
   assign sync_bus.raw = {amp_reset_n_i, overload_trip_i, undervoltage_trip_i,
                          thermal_shutdown_error_i, over_temp_i, bridge_err_i,
                          boot_uv_i}; // [RL15]
   pa_sync #(
      .W(`PA_IN_W),
      .RST_VAL(13'h1000)
   ) u_sync (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .s(sync_bus)
   ); // [RL15]
   assign amp_rst_n_s = sync_bus.sync[12];
   assign ovl_s = sync_bus.sync[11];
   assign uv_s = sync_bus.sync[10];
   assign ote_s = sync_bus.sync[9];
   assign warn_s = sync_bus.sync[8];
   assign br_s = sync_bus.sync[7:4];
   assign boot_s = sync_bus.sync[3:0];

   // Global overload and thermal shutdown latch until the device reset pin is pulsed low.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ovl_lat_q <= 1'b0;
         ote_lat_q <= 1'b0;
      end else if (!amp_rst_n_s) begin
         ovl_lat_q <= 1'b0; // [RL14]
         ote_lat_q <= 1'b0; // [RL13]
      end else begin
         ovl_lat_q <= ovl_lat_q | ovl_s; // [RL7] [RL14]
         ote_lat_q <= ote_lat_q | ote_s; // [RL7] [RL13]
      end
   end

   // Half-bridge overload errors latch per bridge and only stop the bridges they map to.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         br_lat_q <= 4'h0;
      end else if (!amp_rst_n_s) begin
         br_lat_q <= 4'h0;
      end else begin
         br_lat_q <= br_lat_q | br_s; // [RL7] [RL14]
      end
   end

   // Undervoltage is taken live, so the stages return as soon as the supply does.
   assign global_off = ovl_lat_q | ote_lat_q | uv_s; // [RL7] [RL14]
   assign fault_any = global_off | (|br_lat_q); // [RL2]

   always_comb begin
      if (!amp_rst_n_s) begin
         hiz_d = 4'hf;
      end else if (global_off) begin
         hiz_d = 4'hf; // [RL6] [RL14]
      end else begin
         // Bootstrap undervoltage bypasses the mode mapping and touches its own bridge.
         hiz_d = map_off(mode_q, br_lat_q) | boot_s; // [RL6] [RL8] [RL10]
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hiz_q <= 4'hf;
      end else begin
         hiz_q <= hiz_d; // [RL6]
      end
   end

   // The pins only ever pull low; the output enable carries the whole state.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fault_n_oe_q <= 1'b0;
         warn_oe_q <= 1'b0;
      end else begin
         fault_n_oe_q <= amp_rst_n_s & fault_any; // [RL1] [RL2] [RL4] [RL5] [RL6]
         warn_oe_q <= warn_s; // [RL1] [RL3] [RL4]
      end
   end

   always_comb begin
      if (ovl_lat_q | ote_lat_q | (|br_lat_q)) begin
         state_d = pa_prot_pkg::PA_ST_LATCHED;
      end else if (uv_s) begin
         state_d = pa_prot_pkg::PA_ST_RECOVER;
      end else begin
         state_d = pa_prot_pkg::PA_ST_RUN;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= pa_prot_pkg::PA_ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // Rising edges of the synced trips become sticky events.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ovl_s_q <= 1'b0;
         uv_s_q <= 1'b0;
         ote_s_q <= 1'b0;
         warn_s_q <= 1'b0;
         br_s_q <= 4'h0;
         boot_s_q <= 4'h0;
      end else begin
         ovl_s_q <= ovl_s;
         uv_s_q <= uv_s;
         ote_s_q <= ote_s;
         warn_s_q <= warn_s;
         br_s_q <= br_s;
         boot_s_q <= boot_s;
      end
   end

   always_comb begin
      ev_set = '0;
      ev_set[`PA_EV_OVERLOAD] = ovl_s & ~ovl_s_q;
      ev_set[`PA_EV_UNDERVOLT] = uv_s & ~uv_s_q;
      ev_set[`PA_EV_THERMAL] = ote_s & ~ote_s_q;
      ev_set[`PA_EV_WARN] = warn_s & ~warn_s_q;
      ev_set[`PA_EV_BRIDGE] = |(br_s & ~br_s_q);
      ev_set[`PA_EV_BOOT] = |(boot_s & ~boot_s_q);
   end

   // APB: one wait state, so every answer leaves a flop.
   assign acc_done = psel & penable & pready_q;
   assign hit = (paddr == `PA_OFF_CTRL) | (paddr == `PA_OFF_STATUS) |
                (paddr == `PA_OFF_MASK) | (paddr == `PA_OFF_STATE);

   always_comb begin
      rd_word = 32'h0;
      unique case (paddr)
         `PA_OFF_CTRL: rd_word[1:0] = mode_q;
         `PA_OFF_STATUS: rd_word[`PA_EV_W-1:0] = status_q;
         `PA_OFF_MASK: rd_word[`PA_EV_W-1:0] = mask_q;
         `PA_OFF_STATE: rd_word[15:0] = {state_q, warn_oe_q, fault_n_oe_q, ote_lat_q,
                                         ovl_lat_q, uv_s, amp_rst_n_s, br_lat_q, hiz_q};
         default: rd_word = 32'h0;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= psel & penable & ~pready_q;
         prdata_q <= (psel & penable & ~pready_q & ~pwrite) ? rd_word : 32'h0;
         pslverr_q <= psel & penable & ~pready_q & ~hit;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_q <= pa_prot_pkg::pa_mode_t'(`PA_CTRL_RST);
         mask_q <= `PA_MASK_RST;
      end else if (acc_done & pwrite) begin
         if (paddr == `PA_OFF_CTRL) begin
            mode_q <= pa_prot_pkg::pa_mode_t'(pwdata[1:0]); // [RL9]
         end
         if (paddr == `PA_OFF_MASK) begin
            mask_q <= pwdata[`PA_EV_W-1:0];
         end
      end
   end

   // A read clears the status, but an event in the same cycle survives it.
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status_q <= '0;
      end else if (acc_done & ~pwrite & (paddr == `PA_OFF_STATUS)) begin
         status_q <= ev_set;
      end else begin
         status_q <= status_q | ev_set;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(status_q & mask_q);
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign fault_n_o = 1'b0; // [RL1]
   assign fault_n_oe_o = fault_n_oe_q;
   assign temp_warning_n_o = 1'b0; // [RL1]
   assign temp_warning_n_oe_o = warn_oe_q;
   assign hiz_o = hiz_q;
   assign irq_o = irq_q;
endmodule : pa_prot
`default_nettype wire

// >>> tb/pa_prot_sva.sv
// Purpose: Port-level assertions for pa_prot.
// Assumes: Trip inputs are held for several clocks when they matter.
// Notes: Windows allow two synchroniser flops plus the output registers.
`timescale 1ns/1ps
`default_nettype none
module pa_prot_sva (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic amp_reset_n_i,
   input wire logic overload_trip_i,
   input wire logic undervoltage_trip_i,
   input wire logic thermal_shutdown_error_i,
   input wire logic over_temp_i,
   input wire logic [3:0] bridge_err_i,
   input wire logic [3:0] boot_uv_i,
   input wire logic fault_n_o,
   input wire logic fault_n_oe_o,
   input wire logic temp_warning_n_o,
   input wire logic temp_warning_n_oe_o,
   input wire logic [3:0] hiz_o,
   input wire logic irq_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_od_data: assert property (!fault_n_o && !temp_warning_n_o)
      else $error("open-drain data driven high");
   a_uv_fault: assert property ((undervoltage_trip_i && amp_reset_n_i)[*5] |-> fault_n_oe_o)
      else $error("undervoltage did not pull fault");
   a_ovl_latch: assert property ((overload_trip_i && amp_reset_n_i)[*6] |-> fault_n_oe_o && hiz_o == 4'hf)
      else $error("overload did not shut down");
   a_therm_hold: assert property ((thermal_shutdown_error_i && amp_reset_n_i)[*6] ##1 amp_reset_n_i[*3] |-> fault_n_oe_o)
      else $error("thermal latch lost");
   a_warn_on: assert property (over_temp_i[*5] |-> temp_warning_n_oe_o)
      else $error("warning not shown");
   a_warn_off: assert property ((!over_temp_i)[*5] |-> !temp_warning_n_oe_o)
      else $error("warning shown without cause");
   a_reset_fault: assert property ((!amp_reset_n_i)[*4] |-> !fault_n_oe_o && hiz_o == 4'hf)
      else $error("device reset did not release fault");
   a_boot_hiz: assert property (boot_uv_i[2][*5] |-> hiz_o[2])
      else $error("bootstrap stage not off");
   a_apb_wait: assert property ((psel && !penable) ##1 (psel && penable && !pready) |=> pready)
      else $error("bus answer late");
   a_err_pair: assert property (pslverr |-> pready)
      else $error("error without ready");
   c_shut: cover property (fault_n_oe_o && hiz_o == 4'hf);
   c_warn: cover property (temp_warning_n_oe_o && !fault_n_oe_o);
   c_err: cover property (pready && pslverr);
   c_irq: cover property (irq_o);
endmodule : pa_prot_sva
bind pa_prot pa_prot_sva i_sva (.*);
`default_nettype wire

// >>> tb/pa_mcu_model.sv
// Purpose: System controller beside the status pins.
// Assumes: Pins have pull-ups; open-drain drivers only pull low.
// Notes: Volume is lowered once per warning.
`timescale 1ns/1ps
`default_nettype none
module pa_mcu_model #(parameter int SETTLE = 20) (
   input wire logic core_clk_i,
   input wire logic rst_req_i,
   input wire logic fault_d_i,
   input wire logic fault_oe_i,
   input wire logic warn_d_i,
   input wire logic warn_oe_i,
   output logic fault_pin_o,
   output logic warn_pin_o,
   output logic amp_reset_n_o,
   output logic [3:0] volume_o
);
   int settle_q = 0;
   logic warn_q = 1'b1;
   assign fault_pin_o = fault_oe_i ? fault_d_i : 1'b1;
   assign warn_pin_o = warn_oe_i ? warn_d_i : 1'b1;
   assign amp_reset_n_o = (settle_q >= SETTLE) && !rst_req_i;
   initial volume_o = 4'hf;
   always @(posedge core_clk_i) begin
      if (settle_q < SETTLE) settle_q <= settle_q + 1;
      warn_q <= warn_pin_o;
      if (warn_q && !warn_pin_o && volume_o != 4'h0) volume_o <= volume_o - 4'h1;
   end
endmodule : pa_mcu_model
`default_nettype wire

// >>> tb/pa_prot_tb.sv
// Purpose: Directed test of pa_prot over APB and its trip inputs.
// Assumes: Controller model holds device reset low for 20 clocks.
// Notes: Fixed waits follow the three and four edge latencies.
`timescale 1ns/1ps
`default_nettype none
module pa_prot_tb;
   logic core_clk_i, rst_n_i, psel, penable, pwrite, amp_reset_n_i, overload_trip_i;
   logic undervoltage_trip_i, thermal_shutdown_error_i, over_temp_i, pready, pslverr, irq_o;
   logic fault_n_o, fault_n_oe_o, temp_warning_n_o, temp_warning_n_oe_o, fault_pin, warn_pin;
   logic rst_req;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] bridge_err_i, boot_uv_i, hiz_o, vol;
   pa_prot_pkg::pa_mode_t modes [3] = '{pa_prot_pkg::bridged_output_mode,
      pa_prot_pkg::parallel_bridged_mode, pa_prot_pkg::single_ended_mode};
   int miscompares = 0, n_checks = 0;
   pa_prot i_dut (.*);
   pa_mcu_model i_mcu (.core_clk_i(core_clk_i), .rst_req_i(rst_req), .fault_d_i(fault_n_o),
      .fault_oe_i(fault_n_oe_o), .warn_d_i(temp_warning_n_o), .warn_oe_i(temp_warning_n_oe_o),
      .fault_pin_o(fault_pin), .warn_pin_o(warn_pin), .amp_reset_n_o(amp_reset_n_i),
      .volume_o(vol));
   always #20 core_clk_i = ~core_clk_i;
   task automatic report_and_stop;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk_i);
   endtask : cyc
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge core_clk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = pslverr ? 32'hffffffff ^ prdata : prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         miscompares++;
         report_and_stop();
      end
   endtask : apb
   task automatic amp_rst;
      rst_req <= 1'b1;
      cyc(4);
      rst_req <= 1'b0;
      cyc(6);
   endtask : amp_rst
   function automatic logic [3:0] exp_hiz(input logic [1:0] m, input int b);
      if (m == 2'h2) return 4'hf;
      return (b == 0) ? 4'h3 : (b == 1) ? 4'h9 : (b == 2) ? 4'h0 : 4'hc;
   endfunction : exp_hiz
   initial begin
      core_clk_i = 0; rst_n_i = 0; psel = 0; penable = 0; pwrite = 0; paddr = 12'h000;
      pwdata = 32'h0; overload_trip_i = 0; undervoltage_trip_i = 0; rst_req = 0;
      thermal_shutdown_error_i = 0; over_temp_i = 0; bridge_err_i = 4'h0; boot_uv_i = 4'h0;
      cyc(5);
      rst_n_i <= 1'b1;
      undervoltage_trip_i <= 1'b1;
      cyc(6);
      chk("fault held", fault_pin, 1'b1);
      cyc(14);
      chk("fault uv", fault_pin, 1'b0);
      chk("hiz uv", hiz_o, 4'hf);
      undervoltage_trip_i <= 1'b0;
      cyc(6);
      chk("uv recover", {fault_pin, hiz_o}, 5'h10);
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl rst", rd, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk("mask rst", rd, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk("unmapped", rd, 32'hffffffff);
      apb(1'b0, 12'h004, 32'h0);
      apb(1'b1, 12'h008, 32'h8);
      for (int k = 0; k < 2; k++) begin
         over_temp_i <= 1'b1;
         cyc(5);
         chk("warn pins", {fault_pin, warn_pin}, 2'h2);
         chk("irq", irq_o, k == 0);
         over_temp_i <= 1'b0;
         cyc(5);
         apb(1'b0, 12'h004, 32'h0);
         chk("status", rd[5:0], 6'h08);
         cyc(3);
         chk("irq clr", irq_o, 1'b0);
         apb(1'b1, 12'h008, 32'h0);
      end
      chk("volume", vol, 4'hd);
      foreach (modes[m]) for (int b = 0; b < 4; b++) begin
         apb(1'b1, 12'h000, {30'h0, modes[m]});
         bridge_err_i <= 4'h1 << b;
         cyc(3);
         bridge_err_i <= 4'h0;
         cyc(6);
         chk("hiz map", hiz_o, exp_hiz(modes[m], b));
         chk("fault map", fault_pin, 1'b0);
         amp_rst();
      end
      for (int k = 0; k < 2; k++) begin
         if (k == 0) overload_trip_i <= 1'b1;
         else thermal_shutdown_error_i <= 1'b1;
         cyc(3);
         overload_trip_i <= 1'b0;
         thermal_shutdown_error_i <= 1'b0;
         cyc(8);
         chk("latched", {fault_pin, hiz_o}, 5'h0f);
         amp_rst();
         chk("cleared", {fault_pin, hiz_o}, 5'h10);
      end
      boot_uv_i <= 4'h4;
      cyc(5);
      chk("boot", {fault_pin, hiz_o}, 5'h14);
      boot_uv_i <= 4'h0;
      cyc(5);
      chk("boot off", hiz_o, 4'h0);
      report_and_stop();
   end
endmodule : pa_prot_tb
`default_nettype wire
